/* File: pkg/boot_status_cfg.svh */
// address, field and timing constants for the boot status block
`ifndef BOOT_STATUS_CFG_SVH
`define BOOT_STATUS_CFG_SVH

`define BS_RAM_TOP        16'h1200
`define BS_ADDR_RESV      16'h11f3
`define BS_ADDR_USRBEG    16'h11f5
`define BS_ADDR_NEXTFREE  16'h11fd
`define BS_ADDR_STAT      16'h11ff
`define BS_ADDR_STEP      16'h0001
`define BS_NVM_FACTORY    16'h0000
`define BS_SFR_CTRL       8'hdd
`define BS_FLAG_FORCE     5
`define BS_FLAG_RUNPOR    4
`define BS_FLAG_FAIL      2
`define BS_FLAG_DONE      1
`define BS_FLAG_RUNSYS    0
`define BS_CTRL_POR_KEEP  8'h30
`define BS_FERR_SUM       3'h1
`define BS_FERR_RANGE     3'h2
`define BS_STAT_LAST      3'h4
`define BS_PIN_SETTLE     3'h4

`endif

/* File: pkg/boot_status_pkg.sv */
// types shared by the boot status block
package boot_status_pkg;

    typedef enum logic [1:0] {
        LVL_FACTORY,
        LVL_USER,
        LVL_RUN,
        LVL_SPARE
    } prog_level_t;

    typedef enum {
        ST_SAMPLE,
        ST_FETCH,
        ST_WAITB,
        ST_PTR_HI,
        ST_PTR_LO,
        ST_PTR_END,
        ST_STATUS,
        ST_DECIDE,
        ST_HALT,
        ST_RUN
    } boot_state_t;

    typedef enum logic [2:0] {
        FR_DHI,
        FR_DLO,
        FR_LEN,
        FR_DATA,
        FR_SUM
    } frame_field_t;

endpackage

/* File: pkg/ram_if.sv */
// byte port between the boot sequencer and the code/data ram
`timescale 1ns/1ps
interface ram_if #(
    parameter int AW = 13
);
    logic          en;
    logic          we;
    logic [AW-1:0] addr;
    logic [7:0]    wdata;
    logic [7:0]    rdata;

    modport owner (output en, output we, output addr, output wdata, input rdata);
    modport mem   (input en, input we, input addr, input wdata, output rdata);
endinterface

/* File: rtl/boot_ram.sv */
// unified code/data ram, single port, registered read
`timescale 1ns/1ps
module boot_ram #(
    parameter int DEPTH = 4608,
    parameter int AW    = 13
)(
    input  wire logic clk,
    ram_if.mem        port
);
    logic [7:0] mem [DEPTH];

    // read-first: old data returns on a write cycle
    always_ff @(posedge clk) begin
        if (port.en) begin
            if (port.we) begin
                mem[port.addr] <= port.wdata;
            end
            port.rdata <= mem[port.addr];
        end
    end
endmodule

/* File: rtl/boot_status_reporting.sv */
// boot sequencer: nvm loads, status variables, boot control register
`timescale 1ns/1ps
`include "boot_status_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module boot_status_reporting #(
    parameter int RAM_DEPTH = `BS_RAM_TOP,
    parameter int AW        = 13
)(
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        por,
    input  wire logic                        pin_zero,
    input  wire boot_status_pkg::prog_level_t prog_level,
    input  wire logic                        auto_run_user,
    input  wire logic                        debug_connect,
    output logic                             nvm_rd,
    output logic [15:0]                      nvm_addr,
    input  wire logic                        nvm_rvalid,
    input  wire logic [7:0]                  nvm_rdata,
    input  wire logic                        xdata_en,
    input  wire logic                        xdata_we,
    input  wire logic [15:0]                 xdata_addr,
    input  wire logic [7:0]                  xdata_wdata,
    output logic [7:0]                       xdata_rdata,
    input  wire logic                        sfr_wr,
    input  wire logic [7:0]                  sfr_addr,
    input  wire logic [7:0]                  sfr_wdata,
    output logic [7:0]                       sfr_rdata,
    output logic                             boot_busy,
    output logic                             cpu_run
);
    boot_status_pkg::boot_state_t  state_reg;
    boot_status_pkg::frame_field_t field_reg;
    logic [15:0] nvm_ptr_reg;
    logic [15:0] dest_reg;
    logic [15:0] resv_reg;
    logic [7:0]  len_reg;
    logic [7:0]  sum_reg;
    logic [7:0]  ptr_hi_reg;
    logic [7:0]  ctrl_reg;
    logic [7:0]  ctrl_next;
    logic [2:0]  ferr_reg;
    logic [2:0]  stat_idx_reg;
    logic [2:0]  settle_reg;
    logic [2:0]  pin_sync_reg;
    logic        pin_level_reg;
    logic        pin_sample_reg;
    logic        first_err_reg;
    logic        next_err_reg;
    logic        first_blk_reg;
    logic        user_phase_reg;
    logic        dbg_hold_reg;
    logic [7:0]  status_byte;
    logic [7:0]  sum_next;
    logic        byte_valid;
    logic        range_err;
    logic        sum_err;
    logic        frame_err;
    logic        load_end;
    logic        user_load_ok;
    logic        dbg_restart;
    logic        boot_restart;
    logic        run_req;
    logic        status_last;
    logic [15:0] st_addr;
    logic [7:0]  st_data;
    logic [15:0] ptr_word;

    ram_if #(.AW(AW)) ram ();

    boot_ram #(
        .DEPTH (RAM_DEPTH),
        .AW    (AW)
    ) u_ram (
        .clk  (clk),
        .port (ram.mem)
    );

    function automatic logic [15:0] stat_addr(input logic [2:0] idx);
        case (idx)
            3'h0:    stat_addr = `BS_ADDR_RESV;
            3'h1:    stat_addr = `BS_ADDR_RESV + `BS_ADDR_STEP;
            3'h2:    stat_addr = `BS_ADDR_NEXTFREE;
            3'h3:    stat_addr = `BS_ADDR_NEXTFREE + `BS_ADDR_STEP;
            default: stat_addr = `BS_ADDR_STAT;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // status byte layout
    assign status_byte = {pin_sample_reg, 2'b00, ferr_reg, next_err_reg, first_err_reg};
    assign st_addr     = stat_addr(stat_idx_reg);
    always_comb begin
        case (stat_idx_reg)
            3'h0:    st_data = resv_reg[15:8];
            3'h1:    st_data = resv_reg[7:0];
            3'h2:    st_data = nvm_ptr_reg[15:8];
            3'h3:    st_data = nvm_ptr_reg[7:0];
            default: st_data = status_byte;
        endcase
    end

    assign ptr_word     = {ptr_hi_reg, ram.rdata};
    assign byte_valid   = (state_reg == boot_status_pkg::ST_WAITB) && nvm_rvalid;
    assign sum_next     = sum_reg + nvm_rdata;
    // a frame whose data would run past the ram end is refused before any write
    assign range_err    = (field_reg == boot_status_pkg::FR_LEN) &&
                          (({1'b0, dest_reg} + {9'h000, nvm_rdata}) > 17'(RAM_DEPTH));
    assign sum_err      = (field_reg == boot_status_pkg::FR_SUM) && (sum_next != 8'h00);
    assign frame_err    = range_err || sum_err;
    assign load_end     = frame_err || ((field_reg == boot_status_pkg::FR_LEN) && (nvm_rdata == 8'h00));
    // force bit skips the user load at user level only; run level always loads
    assign user_load_ok = (prog_level == boot_status_pkg::LVL_RUN) ||
                          ((prog_level == boot_status_pkg::LVL_USER) && !ctrl_reg[`BS_FLAG_FORCE]);
    // run level has the debug port shut off
    assign dbg_restart  = debug_connect && (prog_level != boot_status_pkg::LVL_RUN);
    assign boot_restart = rst || dbg_restart;
    assign run_req      = ctrl_reg[`BS_FLAG_RUNSYS] || ctrl_reg[`BS_FLAG_RUNPOR];
    assign status_last  = (state_reg == boot_status_pkg::ST_STATUS) && (stat_idx_reg == `BS_STAT_LAST);

    assign nvm_rd      = (state_reg == boot_status_pkg::ST_FETCH);
    assign nvm_addr    = nvm_ptr_reg;
    assign xdata_rdata = ram.rdata;
    assign boot_busy   = (state_reg != boot_status_pkg::ST_HALT) && (state_reg != boot_status_pkg::ST_RUN);
    assign cpu_run     = (state_reg == boot_status_pkg::ST_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // ram ownership: the cpu only reaches ram once boot is out of the way
    always_comb begin
        ram.en    = 1'b0;
        ram.we    = 1'b0;
        ram.addr  = '0;
        ram.wdata = 8'h00;
        if (!boot_busy) begin
            ram.en    = xdata_en && (xdata_addr < 16'(RAM_DEPTH));
            ram.we    = xdata_we;
            ram.addr  = xdata_addr[AW-1:0];
            ram.wdata = xdata_wdata;
        end else if (byte_valid && (field_reg == boot_status_pkg::FR_DATA)) begin
            ram.en    = 1'b1;
            ram.we    = 1'b1;
            ram.addr  = dest_reg[AW-1:0];
            ram.wdata = nvm_rdata;
        end else if (state_reg == boot_status_pkg::ST_PTR_HI) begin
            ram.en    = 1'b1;
            ram.addr  = AW'(`BS_ADDR_USRBEG);
        end else if (state_reg == boot_status_pkg::ST_PTR_LO) begin
            ram.en    = 1'b1;
            ram.addr  = AW'(`BS_ADDR_USRBEG + `BS_ADDR_STEP);
        end else if (state_reg == boot_status_pkg::ST_STATUS) begin
            ram.en    = 1'b1;
            ram.we    = 1'b1;
            ram.addr  = st_addr[AW-1:0];
            ram.wdata = st_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin zero: three stages, a change counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_sync_reg  <= 3'h0;
            pin_level_reg <= 1'b0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], pin_zero};
            if (pin_sync_reg[1] == pin_sync_reg[2]) begin
                pin_level_reg <= pin_sync_reg[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // every system reset, or debug connect outside run level, reruns the whole boot
    always_ff @(posedge clk) begin
        if (boot_restart) begin
            state_reg      <= boot_status_pkg::ST_SAMPLE;
            field_reg      <= boot_status_pkg::FR_DHI;
            nvm_ptr_reg    <= `BS_NVM_FACTORY;
            resv_reg       <= `BS_RAM_TOP;
            dest_reg       <= 16'h0000;
            len_reg        <= 8'h00;
            sum_reg        <= 8'h00;
            ptr_hi_reg     <= 8'h00;
            ferr_reg       <= 3'h0;
            stat_idx_reg   <= 3'h0;
            settle_reg     <= 3'h0;
            pin_sample_reg <= 1'b0;
            first_err_reg  <= 1'b0;
            next_err_reg   <= 1'b0;
            first_blk_reg  <= 1'b0;
            user_phase_reg <= 1'b0;
        end else begin
            case (state_reg)
                boot_status_pkg::ST_SAMPLE: begin
                    settle_reg <= settle_reg + 3'h1;
                    if (settle_reg == `BS_PIN_SETTLE) begin
                        pin_sample_reg <= pin_level_reg;
                        state_reg      <= boot_status_pkg::ST_FETCH;
                    end
                end
                boot_status_pkg::ST_FETCH: begin
                    state_reg <= boot_status_pkg::ST_WAITB;
                end
                boot_status_pkg::ST_WAITB: begin
                    if (nvm_rvalid) begin
                        // pointer always names the first unread byte
                        nvm_ptr_reg <= nvm_ptr_reg + `BS_ADDR_STEP;
                        sum_reg     <= (field_reg == boot_status_pkg::FR_DHI) ? nvm_rdata : sum_next;
                        if (load_end) begin
                            state_reg <= boot_status_pkg::ST_STATUS;
                            if (!user_phase_reg) begin
                                if (frame_err) begin
                                    ferr_reg <= sum_err ? `BS_FERR_SUM : `BS_FERR_RANGE;
                                end else if (user_load_ok) begin
                                    state_reg <= boot_status_pkg::ST_PTR_HI;
                                end
                            end else if (frame_err) begin
                                if (first_blk_reg) begin
                                    first_err_reg <= 1'b1;
                                end else begin
                                    next_err_reg <= 1'b1;
                                end
                            end
                        end else begin
                            state_reg <= boot_status_pkg::ST_FETCH;
                            case (field_reg)
                                boot_status_pkg::FR_DHI: begin
                                    dest_reg[15:8] <= nvm_rdata;
                                    field_reg      <= boot_status_pkg::FR_DLO;
                                end
                                boot_status_pkg::FR_DLO: begin
                                    dest_reg[7:0] <= nvm_rdata;
                                    field_reg     <= boot_status_pkg::FR_LEN;
                                end
                                boot_status_pkg::FR_LEN: begin
                                    len_reg   <= nvm_rdata;
                                    field_reg <= boot_status_pkg::FR_DATA;
                                    // lowest factory destination marks the reserved area
                                    if (!user_phase_reg && (dest_reg < resv_reg)) begin
                                        resv_reg <= dest_reg;
                                    end
                                end
                                boot_status_pkg::FR_DATA: begin
                                    dest_reg <= dest_reg + `BS_ADDR_STEP;
                                    len_reg  <= len_reg - 8'h01;
                                    if (len_reg == 8'h01) begin
                                        field_reg <= boot_status_pkg::FR_SUM;
                                    end
                                end
                                default: begin
                                    field_reg     <= boot_status_pkg::FR_DHI;
                                    first_blk_reg <= 1'b0;
                                end
                            endcase
                        end
                    end
                end
                // user load start pointer read back from ram
                boot_status_pkg::ST_PTR_HI: begin
                    state_reg <= boot_status_pkg::ST_PTR_LO;
                end
                boot_status_pkg::ST_PTR_LO: begin
                    ptr_hi_reg <= ram.rdata;
                    state_reg  <= boot_status_pkg::ST_PTR_END;
                end
                boot_status_pkg::ST_PTR_END: begin
                    nvm_ptr_reg    <= ptr_word;
                    user_phase_reg <= 1'b1;
                    first_blk_reg  <= 1'b1;
                    field_reg      <= boot_status_pkg::FR_DHI;
                    state_reg      <= boot_status_pkg::ST_FETCH;
                end
                // all variables land before leaving boot
                boot_status_pkg::ST_STATUS: begin
                    stat_idx_reg <= stat_idx_reg + 3'h1;
                    if (status_last) begin
                        state_reg <= boot_status_pkg::ST_DECIDE;
                    end
                end
                boot_status_pkg::ST_DECIDE: begin
                    if (!dbg_hold_reg && (prog_level == boot_status_pkg::LVL_RUN)) begin
                        state_reg <= boot_status_pkg::ST_RUN;
                    end else if (!dbg_hold_reg && (prog_level == boot_status_pkg::LVL_USER) &&
                                 auto_run_user && !ctrl_reg[`BS_FLAG_FORCE]) begin
                        state_reg <= boot_status_pkg::ST_RUN;
                    end else begin
                        state_reg <= boot_status_pkg::ST_HALT;
                    end
                end
                // run bit honoured outside run level only
                boot_status_pkg::ST_HALT: begin
                    if (run_req && (prog_level != boot_status_pkg::LVL_RUN)) begin
                        state_reg <= boot_status_pkg::ST_RUN;
                    end
                end
                default: begin
                    state_reg <= boot_status_pkg::ST_RUN;
                end
            endcase
        end
    end

    // halted until the host asks to run
    always_ff @(posedge clk) begin
        if (rst) begin
            dbg_hold_reg <= 1'b0;
        end else if (dbg_restart) begin
            dbg_hold_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register; hardware set wins over a same-cycle software write
    always_comb begin
        ctrl_next = ctrl_reg;
        if (sfr_wr && (sfr_addr == `BS_SFR_CTRL)) begin
            ctrl_next = sfr_wdata;
        end
        if (status_last) begin
            ctrl_next[`BS_FLAG_DONE] = 1'b1;
            // failed flag mirrors a nonzero status
            ctrl_next[`BS_FLAG_FAIL] = (status_byte != 8'h00);
        end
    end

    // power-on clears all; system reset or debug connect spare por bits
    // clearing bit 0 stops a stale run bit releasing a debug-held part; a kept bit 4 still releases it at once
    always_ff @(posedge clk) begin
        if (por) begin
            ctrl_reg <= 8'h00;
        end else if (boot_restart) begin
            ctrl_reg <= ctrl_reg & `BS_CTRL_POR_KEEP;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_addr == `BS_SFR_CTRL) begin
            sfr_rdata <= ctrl_reg;
        end else begin
            sfr_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_enter_status;
        (state_reg == boot_status_pkg::ST_STATUS) && (stat_idx_reg == 3'h0);
    endsequence
    sequence s_resv_pair;
        (st_addr == `BS_ADDR_RESV) && (st_data == resv_reg[15:8]) && ram.we ##1 (st_data == resv_reg[7:0]);
    endsequence
    sequence s_free_pair;
        (st_addr == `BS_ADDR_NEXTFREE) && (st_data == nvm_ptr_reg[15:8]) ##1 (st_data == nvm_ptr_reg[7:0]);
    endsequence

    property p_resv;
        s_enter_status |-> s_resv_pair;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved start word wrong");
    property p_usr_ptr;
        (state_reg == boot_status_pkg::ST_PTR_END) |=> (nvm_ptr_reg == $past(ptr_word));
    endproperty
    a_usr_ptr: assert property (p_usr_ptr) else $error("user load start not taken");
    property p_next_free;
        s_enter_status |-> ##2 s_free_pair ##1 (st_addr == `BS_ADDR_STAT);
    endproperty
    a_next_free: assert property (p_next_free) else $error("next free word wrong");
    property p_stat_byte;
        s_enter_status |-> ##4 ram.we && (st_data[7] == pin_sample_reg) && (st_data[6:5] == 2'b00);
    endproperty
    a_stat_byte: assert property (p_stat_byte) else $error("status byte wrong");
    property p_fail;
        status_last |=> (ctrl_reg[`BS_FLAG_FAIL] == ($past(status_byte) != 8'h00));
    endproperty
    a_fail: assert property (p_fail) else $error("failed flag wrong");
    property p_done;
        status_last |=> ctrl_reg[`BS_FLAG_DONE] ##1 (state_reg != boot_status_pkg::ST_STATUS);
    endproperty
    a_done: assert property (p_done) else $error("finished flag missing");
    property p_force_skip;
        (state_reg == boot_status_pkg::ST_PTR_HI) |->
            !((prog_level == boot_status_pkg::LVL_USER) && ctrl_reg[`BS_FLAG_FORCE]);
    endproperty
    a_force_skip: assert property (p_force_skip) else $error("forced part loaded user data");
    property p_force_keep;
        @(posedge clk) disable iff (por) (rst && !por) |=>
            ((ctrl_reg & `BS_CTRL_POR_KEEP) == ($past(ctrl_reg) & `BS_CTRL_POR_KEEP));
    endproperty
    a_force_keep: assert property (p_force_keep) else $error("por bits lost on system reset");
    property p_dbg;
        dbg_restart |=> (state_reg == boot_status_pkg::ST_SAMPLE) && dbg_hold_reg && !cpu_run;
    endproperty
    a_dbg: assert property (p_dbg) else $error("debug connect did not halt");
    property p_run;
        (state_reg == boot_status_pkg::ST_HALT) && run_req && (prog_level != boot_status_pkg::LVL_RUN) |=> cpu_run;
    endproperty
    a_run: assert property (p_run) else $error("run bit ignored");
    property p_before_run;
        $rose(cpu_run) |-> (stat_idx_reg > `BS_STAT_LAST);
    endproperty
    a_before_run: assert property (p_before_run) else $error("ran before status written");
    property p_sfr;
        (sfr_addr == `BS_SFR_CTRL) |=> (sfr_rdata == $past(ctrl_reg));
    endproperty
    a_sfr: assert property (p_sfr) else $error("control register read wrong");
endmodule

/* File: verification/nvm_model.sv */
// behavioural nvm holding one factory frame and one user frame
`timescale 1ns/1ps
module nvm_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        nvm_rd,
    input  wire logic [15:0] nvm_addr,
    input  wire logic [1:0]  lat,
    input  wire logic [15:0] bad_at,
    output logic             nvm_rvalid,
    output logic [7:0]       nvm_rdata
);
    logic [7:0] mem [0:31];
    logic [2:0] wait_reg;
    ////////////////////////////////////////
    // factory frame leaves user start 0x0010 in ram
    initial begin
        mem = '{0: 8'h11, 1: 8'hf5, 2: 8'h02, 4: 8'h10, 5: 8'he8, 6: 8'h12,
                18: 8'h01, 19: 8'ha5, 20: 8'h5a, default: 8'h00};
    end
    // model never writes ram; released data toggles so stale bytes are not trusted
    always_ff @(posedge clk) begin
        nvm_rvalid <= 1'b0;
        nvm_rdata  <= ~nvm_rdata;
        if (rst) begin
            wait_reg  <= 3'd0;
            nvm_rdata <= 8'h5a;
        end else if (nvm_rd) begin
            wait_reg <= {1'b0, lat} + 3'd1;
        end else if (wait_reg == 3'd1) begin
            wait_reg   <= 3'd0;
            nvm_rvalid <= 1'b1;
            nvm_rdata  <= mem[nvm_addr[4:0]] ^ {7'h00, nvm_addr == bad_at};
        end else if (wait_reg != 3'd0) begin
            wait_reg <= wait_reg - 3'd1;
        end
    end
endmodule

/* File: verification/boot_status_reporting_test.sv */
// self-checking bench for the boot status block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", nm, e, s); end end
module boot_status_reporting_test;
    logic clk, rst, por, pin_zero, sfr_wr, xdata_en, nvm_rd, nvm_rvalid, aru, boot_busy, cpu_run, ld, bad, frc, dbg, fb;
    logic [15:0] nvm_addr, xdata_addr, bad_at;
    logic [7:0]  nvm_rdata, sfr_wdata, sfr_rdata, xdata_rdata, d;
    logic [1:0]  lat;
    logic [31:0] rnd;
    int          err_count, checked, cyc;
    boot_status_pkg::prog_level_t lvl, l;
    boot_status_pkg::prog_level_t lv [7] = '{boot_status_pkg::LVL_FACTORY, boot_status_pkg::LVL_USER,
        boot_status_pkg::LVL_USER, boot_status_pkg::LVL_RUN, boot_status_pkg::LVL_SPARE, boot_status_pkg::LVL_USER,
        boot_status_pkg::LVL_FACTORY};
    boot_status_reporting u_dut (.clk(clk), .rst(rst), .por(por), .pin_zero(pin_zero), .prog_level(lvl),
        .auto_run_user(aru), .debug_connect(dbg), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .nvm_rvalid(nvm_rvalid),
        .nvm_rdata(nvm_rdata), .xdata_en(xdata_en), .xdata_we(1'b0), .xdata_addr(xdata_addr), .xdata_wdata(8'h00),
        .xdata_rdata(xdata_rdata), .sfr_wr(sfr_wr), .sfr_addr(8'hdd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .boot_busy(boot_busy), .cpu_run(cpu_run));
    nvm_model u_nvm (.clk(clk), .rst(rst), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .lat(lat), .bad_at(bad_at),
        .nvm_rvalid(nvm_rvalid), .nvm_rdata(nvm_rdata));
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [15:0] exp_next(input logic load, input logic e);
        return load ? (e ? 16'h0015 : 16'h0018) : 16'h0009;
    endfunction
    task automatic summarize;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk);
        xdata_en <= 1'b1;
        xdata_addr <= a;
        @(posedge clk);
        xdata_en <= 1'b0;
        @(negedge clk);
        v = xdata_rdata;
    endtask
    task automatic wr(input logic [7:0] v);
        @(posedge clk);
        sfr_wr <= 1'b1;
        sfr_wdata <= v;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    // warm reset keeps the force bit, cold reset clears everything
    task automatic boot(input logic p, input logic cold);
        @(posedge clk);
        rst <= 1'b1;
        por <= cold;
        lvl <= l;
        pin_zero <= p;
        aru <= (l == boot_status_pkg::LVL_USER);
        // user checksum byte or factory checksum byte flipped
        bad_at <= bad ? 16'h0014 : (fb ? 16'h0005 : 16'hffff);
        lat <= rnd[1:0];
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
        repeat (2) @(negedge clk);
        `CHK("ctrl_reset", {2'b00, frc, 5'h00}, sfr_rdata)
        while (boot_busy !== 1'b0) @(negedge clk);
    endtask
    task automatic check(input logic [7:0] st, input logic [15:0] nf);
        logic [7:0] h;
        logic [7:0] lo;
        rd(16'h11f3, h);
        rd(16'h11f4, lo);
        `CHK("reserved_area_start", 16'h11f5, {h, lo})
        rd(16'h11fd, h);
        rd(16'h11fe, lo);
        `CHK("next_free_nvm_address", nf, {h, lo})
        rd(16'h11ff, h);
        `CHK("boot_result", st, h)
        `CHK("boot_control", {2'b00, frc, 2'b00, st != 8'h00, 2'b10}, sfr_rdata)
        `CHK("cpu_run", ld, cpu_run)
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
    end
    initial begin
        {rst, por, pin_zero, sfr_wr, xdata_en, aru, bad, frc, dbg, fb} = 10'h300;
        {sfr_wdata, xdata_addr, bad_at, lat, cyc, err_count, checked} = '0;
        lvl = boot_status_pkg::LVL_FACTORY;
        l = lvl;
        rnd = 32'h8818b510;
        for (int i = 0; i < 7; i++) begin
            rnd = lfsr(rnd);
            l = lv[i];
            bad = (i == 2);
            frc = (i == 5);
            fb = (i == 6);
            if (frc) wr(8'h20);
            boot(rnd[2], !frc);
            ld = (l == boot_status_pkg::LVL_USER && !frc) || l == boot_status_pkg::LVL_RUN;
            check({rnd[2], 4'h0, fb, 1'b0, ld && bad}, fb ? 16'h0006 : exp_next(ld, bad));
            rd(16'h0000, d);
            if (ld && !bad) `CHK("user_byte", 8'ha5, d)
            // debug connect on an auto-running part must reboot and stay halted
            if (i == 1) begin
                @(posedge clk);
                dbg <= 1'b1;
                @(posedge clk);
                dbg <= 1'b0;
                @(negedge clk);
                `CHK("boot_busy", 1'b1, boot_busy)
                while (boot_busy !== 1'b0) @(negedge clk);
                `CHK("cpu_run", 1'b0, cpu_run)
            end
            if (l != boot_status_pkg::LVL_RUN) begin
                wr(8'h01);
                repeat (2) @(negedge clk);
                `CHK("cpu_run", 1'b1, cpu_run)
            end
        end
        summarize();
    end
endmodule
